// >>> cire_regs.svh
`ifndef CIRE_REGS_SVH
`define CIRE_REGS_SVH
// Flags bit positions
`define CIRE_FLAG_CHAIN_BIT   1
`define CIRE_FLAG_MASTER_BIT  7
// Reset values
`define CIRE_FLAGS_RESET      8'h00
`define CIRE_PC_RESET         32'h0000_0000
`define CIRE_SP_RESET         32'h0000_0000
// Fixed system exception vector quad address
`define CIRE_EXC_VECTOR_ADDR  32'h0000_0008
// Stack adjustment counts
`define CIRE_EXC_SP_STEP1     32'h0000_0001
`define CIRE_EXC_SP_STEP2     32'h0000_0005
`define CIRE_PAD_BYTE         8'h00
// Exception cause bit positions
`define CIRE_CAUSE_PCOV       0
`define CIRE_CAUSE_SPOV       1
`define CIRE_CAUSE_DIV0       2
`define CIRE_CAUSE_DIVOVF     3
`define CIRE_CAUSE_ILL        4
`endif

// >>> cire_pkg.sv
package cire_pkg;
  // Sequencer states
  typedef enum logic [4:0] {
    CIRE_IDLE,
    CIRE_RET_PC3, CIRE_RET_PC2, CIRE_RET_PC1, CIRE_RET_PC0,
    CIRE_RET_FLAGS,
    CIRE_ENT_FLAGS, CIRE_ENT_PAD, CIRE_ENT_PC0, CIRE_ENT_PC1,
    CIRE_ENT_PC2, CIRE_ENT_PC3,
    CIRE_EXC_FLAGS, CIRE_EXC_PC,
    CIRE_VEC3, CIRE_VEC2, CIRE_VEC1, CIRE_VEC0
  } cire_state_t;
endpackage

// >>> cire_core.sv
`timescale 1ns/100ps
`include "cire_regs.svh"
// Functional notes
// - Normal return pops PC high byte first
// - Normal return skips one padding byte
// - Normal return pops flags, then resumes
// - Chained return clears master enable only
// - Chained return loads top-priority vector directly
// - Entry copies prior master enable to chain
// - Chain flag is flags bit 1, writable
// - Higher priority of simultaneous requests wins
// - Re-enabled routine may be preempted
// - Software set creates normal pending request
// - Disabled requests only visible for polling
// - Writing one clears a pending request
// - Exceptions ignore master enable and masks
// - Five exception causes are supported
// - Exception stacks flags and next PC high byte only
// - Exception vector fetched from fixed quad
// - Exception: SP minus one, minus five
// - Entry pushes flags, pad, PC, clears enable
// - Enable/disable instructions set/clear master enable
module cire_core
  import cire_pkg::*;
#(
  parameter int NUM_IRQ = 8
) (
  input  wire logic               i_clock,
  input  wire logic               i_resetn,
  input  wire logic [NUM_IRQ-1:0] i_irq_lines,
  input  wire logic [NUM_IRQ-1:0] i_irq_enable,
  input  wire logic [NUM_IRQ-1:0] i_request_set_reg_one,
  input  wire logic [NUM_IRQ-1:0] i_request_clear,
  input  wire logic [4:0]         i_exc_cause,
  input  wire logic [31:0]        i_next_pc,
  input  wire logic               i_interrupt_return_instr,
  input  wire logic               i_global_enable_instr,
  input  wire logic               i_global_disable_instr,
  input  wire logic               i_flags_write,
  input  wire logic [7:0]         i_flags_wdata,
  input  wire logic               i_sp_write,
  input  wire logic [31:0]        i_sp_wdata,
  input  wire logic [7:0]         i_mem_rdata,
  output logic [NUM_IRQ-1:0]      o_irq_pending,
  output logic [4:0]              o_exc_status,
  output logic [7:0]              o_flags,
  output logic [31:0]             o_pc,
  output logic [31:0]             o_sp,
  output logic                    o_mem_read,
  output logic                    o_mem_write,
  output logic [31:0]             o_mem_addr,
  output logic [7:0]              o_mem_wdata,
  output logic                    o_busy,
  output logic                    o_resume
);

  localparam int IW = (NUM_IRQ > 1) ? $clog2(NUM_IRQ) : 1;

  cire_state_t            state_reg;      // Sequencer state
  logic [NUM_IRQ-1:0]     sync1_reg;      // Request line first stage
  logic [NUM_IRQ-1:0]     sync2_reg;      // Request line second stage
  logic [NUM_IRQ-1:0]     line_prev_reg;  // For rising-edge detect
  logic [NUM_IRQ-1:0]     pend_reg;       // Pending request bits
  logic [4:0]             exc_sync1_reg;  // Exception cause first stage
  logic [4:0]             exc_sync2_reg;  // Exception cause second stage
  logic [4:0]             exc_prev_reg;   // Cause edge detect
  logic [4:0]             exc_pend_reg;   // Exceptions awaiting entry
  logic [7:0]             flags_reg;      // Flags register
  logic [31:0]            pc_reg;         // Program counter
  logic [31:0]            sp_reg;         // Stack pointer
  logic [31:0]            vec_addr_reg;   // Vector quad address in use
  logic                   prior_ie_reg;   // Master enable before entry
  logic                   rd_reg;         // Memory read strobe
  logic                   wr_reg;         // Memory write strobe
  logic [31:0]            addr_reg;       // Memory address
  logic [7:0]             wdata_reg;      // Memory write data
  logic                   resume_reg;     // One-cycle resume pulse
  logic                   pop_flags_reg;  // Last read of a return carries flags

  logic [NUM_IRQ-1:0]     active;         // Pending and enabled
  logic                   any_active;     // Some vectored request ready
  logic [IW-1:0]          top_idx;        // Highest-priority index
  logic                   master_ie;      // Master enable bit
  logic                   chain_enable_flag; // Chain enable bit
  logic                   idle;           // Sequencer free

  assign master_ie         = flags_reg[`CIRE_FLAG_MASTER_BIT];
  assign chain_enable_flag = flags_reg[`CIRE_FLAG_CHAIN_BIT];
  // Not idle while the last read byte of a sequence is still landing
  assign idle              = (state_reg == CIRE_IDLE) && !rd_reg;

  // Priority encoder: lowest index is highest priority
  // Only enabled bits compete; masked bits stay visible for polling
  always_comb begin
    active     = pend_reg & i_irq_enable;
    any_active = |active;
    top_idx    = '0;
    for (int k = NUM_IRQ - 1; k >= 0; k--) begin
      if (active[k]) begin
        top_idx = IW'(k);
      end
    end
  end

  // Two-flop synchronisers for external request lines and causes
  // The third stage only remembers the last value for edge detection
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_reg     <= '0;
      sync2_reg     <= '0;
      line_prev_reg <= '0;
      exc_sync1_reg <= '0;
      exc_sync2_reg <= '0;
      exc_prev_reg  <= '0;
    end else begin
      sync1_reg     <= i_irq_lines;
      sync2_reg     <= sync1_reg;
      line_prev_reg <= sync2_reg;
      exc_sync1_reg <= i_exc_cause;
      exc_sync2_reg <= exc_sync1_reg;
      exc_prev_reg  <= exc_sync2_reg;
    end
  end

  // Pending bits per source; set wins over clear
  // A chained return leaves its bit pending; software clears it
  generate
    for (genvar g = 0; g < NUM_IRQ; g++) begin : g_pend
      logic taken;  // This source is being vectored
      assign taken = idle && (top_idx == IW'(g)) && active[g] && master_ie
                     && !i_interrupt_return_instr && exc_pend_reg == 5'h00;
      always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          pend_reg[g] <= 1'b0;
        end else if ((sync2_reg[g] && !line_prev_reg[g]) || i_request_set_reg_one[g]) begin
          pend_reg[g] <= 1'b1;
        end else if (i_request_clear[g] || taken) begin
          pend_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Exception pending bits, cleared when entry starts
  // Causes that arrive mid-sequence wait here until the sequencer is free
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      exc_pend_reg <= '0;
    end else begin
      for (int c = 0; c < 5; c++) begin
        if (exc_sync2_reg[c] && !exc_prev_reg[c]) begin
          exc_pend_reg[c] <= 1'b1;
        end else if (idle && !i_interrupt_return_instr) begin
          exc_pend_reg[c] <= 1'b0;
        end
      end
    end
  end

  // Main sequencer: entry, exception and return
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg    <= CIRE_IDLE;
      flags_reg    <= `CIRE_FLAGS_RESET;
      pc_reg       <= `CIRE_PC_RESET;
      sp_reg       <= `CIRE_SP_RESET;
      vec_addr_reg <= '0;
      prior_ie_reg <= 1'b0;
      rd_reg       <= 1'b0;
      wr_reg       <= 1'b0;
      addr_reg     <= '0;
      wdata_reg    <= '0;
      resume_reg   <= 1'b0;
      pop_flags_reg <= 1'b0;
    end else begin
      rd_reg     <= 1'b0;
      wr_reg     <= 1'b0;
      resume_reg <= 1'b0;
      case (state_reg)
        CIRE_IDLE: begin
          // Control inputs are refused in the landing cycle
          if (i_flags_write && idle) begin
            flags_reg <= i_flags_wdata;
          end else if (i_global_enable_instr && idle) begin
            flags_reg[`CIRE_FLAG_MASTER_BIT] <= 1'b1;
          end else if (i_global_disable_instr && idle) begin
            flags_reg[`CIRE_FLAG_MASTER_BIT] <= 1'b0;
          end
          if (i_sp_write && idle) begin
            sp_reg <= i_sp_wdata;
          end
          if (!idle) begin
            // Last byte lands now: resume once PC and flags are whole
            resume_reg <= 1'b1;
          end else if (i_interrupt_return_instr) begin
            if (chain_enable_flag && any_active) begin
              flags_reg[`CIRE_FLAG_MASTER_BIT] <= 1'b0;
              vec_addr_reg <= {{(30-IW){1'b0}}, top_idx, 2'b00};
              state_reg    <= CIRE_VEC3;
            end else begin
              state_reg <= CIRE_RET_PC3;
            end
          end else if (exc_pend_reg != 5'h00) begin
            pc_reg       <= i_next_pc;
            prior_ie_reg <= master_ie;
            vec_addr_reg <= `CIRE_EXC_VECTOR_ADDR;
            state_reg    <= CIRE_EXC_FLAGS;
          end else if (any_active && master_ie) begin
            pc_reg       <= i_next_pc;
            prior_ie_reg <= master_ie;
            vec_addr_reg <= {{(30-IW){1'b0}}, top_idx, 2'b00};
            state_reg    <= CIRE_ENT_FLAGS;
          end
        end
        // Normal return: PC bytes most significant first
        CIRE_RET_PC3, CIRE_RET_PC2, CIRE_RET_PC1, CIRE_RET_PC0: begin
          rd_reg   <= 1'b1;
          addr_reg <= sp_reg;
          sp_reg   <= sp_reg + 32'h1;
          state_reg <= cire_state_t'(state_reg + 5'd1);
        end
        CIRE_RET_FLAGS: begin
          rd_reg    <= 1'b1;
          addr_reg  <= sp_reg + 32'h1;
          sp_reg    <= sp_reg + 32'h2;
          state_reg <= CIRE_IDLE;
          // Flags byte lands next cycle and raises the resume pulse there
          pop_flags_reg <= 1'b1;
        end
        // Interrupt entry pushes
        CIRE_ENT_FLAGS: begin
          wr_reg    <= 1'b1;
          addr_reg  <= sp_reg - 32'h1;
          wdata_reg <= flags_reg;
          sp_reg    <= sp_reg - 32'h1;
          flags_reg[`CIRE_FLAG_CHAIN_BIT] <= prior_ie_reg;
          state_reg <= CIRE_ENT_PAD;
        end
        CIRE_ENT_PAD: begin
          wr_reg    <= 1'b1;
          addr_reg  <= sp_reg - 32'h1;
          wdata_reg <= `CIRE_PAD_BYTE;
          sp_reg    <= sp_reg - 32'h1;
          state_reg <= CIRE_ENT_PC0;
        end
        CIRE_ENT_PC0, CIRE_ENT_PC1, CIRE_ENT_PC2, CIRE_ENT_PC3: begin
          wr_reg   <= 1'b1;
          addr_reg <= sp_reg - 32'h1;
          sp_reg   <= sp_reg - 32'h1;
          case (state_reg)
            CIRE_ENT_PC0: wdata_reg <= pc_reg[7:0];
            CIRE_ENT_PC1: wdata_reg <= pc_reg[15:8];
            CIRE_ENT_PC2: wdata_reg <= pc_reg[23:16];
            default:      wdata_reg <= pc_reg[31:24];
          endcase
          if (state_reg == CIRE_ENT_PC3) begin
            flags_reg[`CIRE_FLAG_MASTER_BIT] <= 1'b0;
            state_reg <= CIRE_VEC3;
          end else begin
            state_reg <= cire_state_t'(state_reg + 5'd1);
          end
        end
        // Exception stacking: flags at SP-1, PC high byte at SP-6
        CIRE_EXC_FLAGS: begin
          wr_reg    <= 1'b1;
          addr_reg  <= sp_reg - `CIRE_EXC_SP_STEP1;
          wdata_reg <= flags_reg;
          sp_reg    <= sp_reg - `CIRE_EXC_SP_STEP1;
          flags_reg[`CIRE_FLAG_CHAIN_BIT] <= prior_ie_reg;
          state_reg <= CIRE_EXC_PC;
        end
        CIRE_EXC_PC: begin
          wr_reg    <= 1'b1;
          addr_reg  <= sp_reg - `CIRE_EXC_SP_STEP2;
          wdata_reg <= pc_reg[31:24];
          sp_reg    <= sp_reg - `CIRE_EXC_SP_STEP2;
          state_reg <= CIRE_VEC3;
        end
        // Vector fetch, four byte reads high first
        CIRE_VEC3, CIRE_VEC2, CIRE_VEC1, CIRE_VEC0: begin
          rd_reg    <= 1'b1;
          addr_reg  <= vec_addr_reg;
          vec_addr_reg <= vec_addr_reg + 32'h1;
          if (state_reg == CIRE_VEC0) begin
            // Low vector byte lands next cycle, then execution resumes
            state_reg     <= CIRE_IDLE;
            pop_flags_reg <= 1'b0;
          end else begin
            state_reg <= cire_state_t'(state_reg + 5'd1);
          end
        end
        default: begin
          state_reg <= CIRE_IDLE;
        end
      endcase
      // Read data stands with its strobe and is taken at the edge that ends it,
      // so each byte lands while the sequencer has moved one state on
      if (rd_reg) begin
        case (state_reg)
          CIRE_RET_PC2, CIRE_VEC2: pc_reg[31:24] <= i_mem_rdata;
          CIRE_RET_PC1, CIRE_VEC1: pc_reg[23:16] <= i_mem_rdata;
          CIRE_RET_PC0, CIRE_VEC0: pc_reg[15:8]  <= i_mem_rdata;
          CIRE_RET_FLAGS:          pc_reg[7:0]   <= i_mem_rdata;
          CIRE_IDLE: begin
            if (pop_flags_reg) begin
              flags_reg <= i_mem_rdata;
            end else begin
              pc_reg[7:0] <= i_mem_rdata;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Registered status outputs
  // Status outputs lag the internal state by one cycle
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq_pending <= '0;
      o_exc_status  <= '0;
      o_busy        <= 1'b0;
    end else begin
      o_irq_pending <= pend_reg;
      o_exc_status  <= exc_pend_reg;
      o_busy        <= !idle;
    end
  end

  // Remaining outputs come straight from their registers
  assign o_flags     = flags_reg;
  assign o_pc        = pc_reg;
  assign o_sp        = sp_reg;
  assign o_mem_read  = rd_reg;
  assign o_mem_write = wr_reg;
  assign o_mem_addr  = addr_reg;
  assign o_mem_wdata = wdata_reg;
  assign o_resume    = resume_reg;

endmodule // cire_core

// >>> cire_mem_model.sv
`timescale 1ns/100ps
// Byte memory on the far side: holds the stack and the vector quads
module cire_mem_model (
  input  wire logic        i_clock,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata
);
  logic [7:0] mem [256];  // Low 256 bytes of the address space
  // Vector quad i holds 0x0010_0000 + 16*i, high byte at the lowest address
  initial begin
    for (int i = 0; i < 64; i++) begin
      {mem[4*i], mem[4*i+1], mem[4*i+2], mem[4*i+3]} = 32'h0010_0000 + 32'(i) * 32'h10;
    end
  end
  // Writes land on the clock edge that sees the strobe
  always @(posedge i_clock) begin
    if (i_write) mem[i_addr[7:0]] <= i_wdata;
  end
  // Read data stands while the strobe is high; between reads the bus shows the inverse
  assign o_rdata = i_read ? mem[i_addr[7:0]] : ~mem[i_addr[7:0]];
endmodule // cire_mem_model

// >>> cire_checker.sv
`timescale 1ns/100ps
// Port-level checks of the return and entry sequencer
module cire_checker
  import cire_pkg::*;
#(
  parameter int NUM_IRQ = 8
) (
  input wire logic               i_clock,
  input wire logic               i_resetn,
  input wire logic [NUM_IRQ-1:0] i_irq_enable,
  input wire logic [NUM_IRQ-1:0] i_request_set_reg_one,
  input wire logic [NUM_IRQ-1:0] i_request_clear,
  input wire logic               i_interrupt_return_instr,
  input wire logic [NUM_IRQ-1:0] o_irq_pending,
  input wire logic [4:0]         o_exc_status,
  input wire logic [7:0]         o_flags,
  input wire logic               o_mem_read,
  input wire logic               o_mem_write,
  input wire logic [31:0]        o_mem_addr,
  input wire logic [7:0]         o_mem_wdata,
  input wire logic               o_busy,
  input wire logic               o_resume
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // Return taken with chaining on and an enabled request pending
  sequence s_chain_req;
    i_interrupt_return_instr && !o_busy && o_flags[1] && |(o_irq_pending & i_irq_enable);
  endsequence
  sequence s_no_push4;
    !o_mem_write [*4];
  endsequence
  property p_chain_nopush; s_chain_req |=> s_no_push4; endproperty
  a_chain_nopush: assert property (p_chain_nopush) else $error("chained return pushed");
  property p_chain_done; s_chain_req |-> ##[1:6] o_resume; endproperty
  a_chain_done: assert property (p_chain_done) else $error("chained return late");
  property p_rw_excl; !(o_mem_read && o_mem_write); endproperty
  a_rw_excl: assert property (p_rw_excl) else $error("read and write together");
  // Pushes step down by one, or by five after the exception flags byte
  property p_push_step;
    o_mem_write && $past(o_mem_write) |-> (o_mem_addr == $past(o_mem_addr) - 32'h1) ||
      (o_mem_addr == $past(o_mem_addr) - 32'h5);
  endproperty
  a_push_step: assert property (p_push_step) else $error("push address step wrong");
  // Pops and vector reads climb by one, or by two over the padding byte
  property p_pop_step;
    o_mem_read && $past(o_mem_read) |-> (o_mem_addr == $past(o_mem_addr) + 32'h1) ||
      (o_mem_addr == $past(o_mem_addr) + 32'h2);
  endproperty
  a_pop_step: assert property (p_pop_step) else $error("pop address step wrong");
  // First byte pushed is the flags as they stood before entry
  property p_flags_first;
    o_mem_write && !$past(o_mem_write) |-> o_mem_wdata == $past(o_flags);
  endproperty
  a_flags_first: assert property (p_flags_first) else $error("first push not flags");
  property p_resume_busy; o_resume |-> $past(o_busy) ##1 !o_resume; endproperty
  a_resume_busy: assert property (p_resume_busy) else $error("resume not a pulse");
  // Pending view lags a set or clear by two samples
  property p_set_pend;
    (i_request_set_reg_one != '0) && !o_flags[7] |-> ##2
      (o_irq_pending & $past(i_request_set_reg_one, 2)) == $past(i_request_set_reg_one, 2);
  endproperty
  a_set_pend: assert property (p_set_pend) else $error("set request not pending");
  property p_clr_pend;
    (i_request_clear != '0) && (i_request_set_reg_one == '0) |-> ##2
      (o_irq_pending & $past(i_request_clear, 2)) == '0;
  endproperty
  a_clr_pend: assert property (p_clr_pend) else $error("cleared request still pending");
  // A pending exception starts entry next cycle whatever the enables
  property p_exc_taken; (o_exc_status != 5'h00) && !o_busy |=> o_busy; endproperty
  a_exc_taken: assert property (p_exc_taken) else $error("exception not taken");
endmodule // cire_checker
bind cire_core cire_checker #(.NUM_IRQ(NUM_IRQ)) u_chk (.i_clock(i_clock), .i_resetn(i_resetn),
  .i_irq_enable(i_irq_enable), .i_request_set_reg_one(i_request_set_reg_one),
  .i_request_clear(i_request_clear), .i_interrupt_return_instr(i_interrupt_return_instr),
  .o_irq_pending(o_irq_pending), .o_exc_status(o_exc_status), .o_flags(o_flags),
  .o_mem_read(o_mem_read),
  .o_mem_write(o_mem_write), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
  .o_busy(o_busy), .o_resume(o_resume));

// >>> tb.sv
`timescale 1ns/100ps
module tb;
  import cire_pkg::*;
  typedef struct {logic [31:0] pc; logic [7:0] fl; logic [7:0] mask;} cire_exp_t;
  localparam logic [31:0] EXC_VEC = 32'h0010_0020;  // Content of quad 2, address 8
  logic        i_clock, i_resetn, ret, ei, di, fw, spw, mrd, mwr, busy, resume;
  logic [7:0]  lines, ien, sset, sclr, fwd, rdata, pend, flags, mwd;
  logic [4:0]  cause, excs;
  logic [31:0] npc, spd, pc, sp, maddr, seed, p0, p1, p2;
  cire_exp_t   exp_q[$];  // Notes of expected resume points
  cire_exp_t   e;
  int          mismatches = 0, checks = 0;
  cire_core #(.NUM_IRQ(8)) u_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_irq_lines(lines),
    .i_irq_enable(ien), .i_request_set_reg_one(sset), .i_request_clear(sclr),
    .i_exc_cause(cause), .i_next_pc(npc), .i_interrupt_return_instr(ret),
    .i_global_enable_instr(ei), .i_global_disable_instr(di), .i_flags_write(fw),
    .i_flags_wdata(fwd), .i_sp_write(spw), .i_sp_wdata(spd), .i_mem_rdata(rdata),
    .o_irq_pending(pend), .o_exc_status(excs), .o_flags(flags), .o_pc(pc), .o_sp(sp),
    .o_mem_read(mrd), .o_mem_write(mwr), .o_mem_addr(maddr), .o_mem_wdata(mwd),
    .o_busy(busy), .o_resume(resume));
  cire_mem_model u_mem (.i_clock(i_clock), .i_read(mrd), .i_write(mwr), .i_addr(maddr),
    .i_wdata(mwd), .o_rdata(rdata));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] vec(input int i);
    return 32'h0010_0000 + 32'(i) * 32'h10;
  endfunction
  task automatic chk_pc(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_byte(input string n, input logic [7:0] x, input logic [7:0] g);
    chk_pc(n, {24'h0, x}, {24'h0, g});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One-cycle strobe: 0 return, 1 enable, 2 disable, 3 set, 4 clear, 5 flags write
  task automatic strobe(input int k, input logic [7:0] v);
    @(posedge i_clock);
    fwd <= v;
    case (k)
      0: ret <= 1'b1;
      1: ei <= 1'b1;
      2: di <= 1'b1;
      3: sset <= v;
      4: sclr <= v;
      default: fw <= 1'b1;
    endcase
    @(posedge i_clock);
    {ret, ei, di, fw, sset, sclr} <= '0;
  endtask
  // Notes the expected resume and waits for it under a bound
  task automatic seq(input logic [31:0] p, input logic [7:0] f, input logic [7:0] m);
    int n;
    n = 0;
    exp_q.push_back('{p, f, m});
    while (exp_q.size() != 0 && n < 60) begin
      @(posedge i_clock);
      n++;
    end
    if (exp_q.size() != 0) begin
      mismatches++;
      $display("ERROR resume expected %h seen none", p);
      give_verdict();
    end
    repeat (3) @(posedge i_clock);
  endtask
  task automatic new_pc(output logic [31:0] p);
    seed = lfsr(seed);
    p = seed & 32'hffff_fffe;
    npc <= p;
  endtask
  // Watches resume and compares against the oldest note
  always @(posedge i_clock) begin
    if (resume === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("ERROR resume expected none seen %h", pc);
      end else begin
        e = exp_q.pop_front();
        chk_pc("pc", e.pc, pc);
        @(posedge i_clock);
        chk_byte("flags", e.fl & e.mask, flags & e.mask);
      end
    end
  end
  initial begin
    {lines, ien, sset, sclr, fwd, cause, ret, ei, di, fw, spw} = '0;
    {npc, p0, p1, p2} = '0;
    spd = 32'h0000_0080;
    seed = 32'h781d;
    i_resetn = 1'b0;
    repeat (4) @(posedge i_clock);
    i_resetn <= 1'b1;
    @(posedge i_clock);
    spw <= 1'b1;
    ien <= 8'hff;
    @(posedge i_clock);
    spw <= 1'b0;
    strobe(5, 8'h82);
    @(posedge i_clock);
    chk_byte("flags", 8'h82, flags);
    new_pc(p0);
    lines <= 8'h28;
    seq(vec(3), 8'h02, 8'hff);
    strobe(4, 8'h08);
    strobe(0, 8'h00);
    seq(vec(5), 8'h02, 8'hff);
    strobe(4, 8'h20);
    strobe(0, 8'h00);
    seq(p0, 8'h82, 8'hff);
    chk_pc("sp", 32'h80, sp);
    new_pc(p1);
    strobe(3, 8'h10);
    seq(vec(4), 8'h02, 8'hff);
    new_pc(p2);
    strobe(1, 8'h00);
    lines <= 8'h2a;
    seq(vec(1), 8'h02, 8'hff);
    strobe(4, 8'h12);
    strobe(0, 8'h00);
    seq(p2, 8'h82, 8'hff);
    strobe(0, 8'h00);
    seq(p1, 8'h82, 8'hff);
    strobe(2, 8'h00);
    strobe(3, 8'h40);
    repeat (4) @(posedge i_clock);
    chk_byte("flags", 8'h02, flags);
    chk_byte("pending", 8'h40, pend & 8'h40);
    strobe(4, 8'h40);
    repeat (2) @(posedge i_clock);
    chk_byte("pending", 8'h00, pend & 8'h40);
    for (int k = 0; k < 5; k++) begin
      new_pc(p0);
      cause <= 5'h01 << k;
      seq(EXC_VEC, 8'h00, 8'h82);
      cause <= 5'h00;
      @(posedge i_clock);
      chk_pc("sp", 32'h80 - 32'(6 * (k + 1)), sp);
      chk_byte("stacked pc", p0[31:24], u_mem.mem[sp[7:0]]);
    end
    give_verdict();
  end
endmodule // tb
